/* src/pcd_port_dma.sv */
// per-port command fetch and scatter/gather dma engine
// What this block does
// - keep a 32-bit running count of bytes moved, either direction
// - upper table base word used only with wide addressing, else ignored
// - set the taskfile busy flag before sending the command frame
// - multiplier port number is sent as written, never inserted
// - send only as many packet bytes as the pio setup asks
// - send the packet region only for commands marked as packet
// - accept scatter/gather lists of zero up to 65535 entries
// - walk entries in order from 0 to list length minus one
// - upper block base word used only with wide addressing
// - entry with done bit set raises done flag, and interrupt if enabled
// - block byte count is bits 21:0, zero based, odd value
// - one independent engine per port
// - watch the issue bitmap continuously for pending commands
// - handle posted commands one at a time, in linear order
// - stop fetching entries at the list length; zero means no data
// - frame length from 5-bit header field, 0 and 1 illegal, max 16
// - packet flag means a pio setup will ask for the packet
module pcd_port_dma
	import pcd_pkg::*;
#(
	parameter int NUM_SLOTS = 32
) (
	// clock and reset
	input  wire logic        I_REF_CLK,
	input  wire logic        I_SRST,
	// control from port registers, same clock domain
	input  wire logic [31:0] I_COMMAND_ISSUE_BITMAP,
	input  wire logic [63:0] I_LIST_BASE,
	input  wire logic        I_WIDE_ADDRESS_CAPABLE,
	input  wire logic        I_IRQ_ENABLE,
	input  wire logic        I_DESCRIPTOR_DONE_CLR,
	// pio setup from the link receive logic
	input  wire logic        I_PIO_SETUP_VALID,
	input  wire logic [4:0]  I_PIO_SETUP_BYTES,
	// system memory port, one word per request
	output logic             O_MEM_REQ,
	output logic             O_MEM_WE,
	output logic [63:0]      O_MEM_ADDR,
	output logic [31:0]      O_MEM_WDATA,
	input  wire logic        I_MEM_ACK,
	input  wire logic [31:0] I_MEM_RDATA,
	// link transmit stream
	output logic             O_TX_VALID,
	output logic [31:0]      O_TX_DATA,
	input  wire logic        I_TX_READY,
	// link receive stream
	input  wire logic        I_RX_VALID,
	input  wire logic [31:0] I_RX_DATA,
	output logic             O_RX_READY,
	// status
	output logic             O_TASKFILE_BUSY_FLAG,
	output logic             O_DESCRIPTOR_DONE_FLAG,
	output logic             O_IRQ,
	output logic [31:0]      O_TRANSFERRED_BYTE_COUNT,
	output logic             O_CMD_DONE,
	output logic [4:0]       O_CMD_SLOT
);
	localparam int SW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;

	pcd_state_type    state;
	logic [SW-1:0]    slot;
	logic             served [32];
	logic [31:0]      hdr_flags;
	logic [31:0]      tbl_lo;
	logic [31:0]      tbl_hi;
	logic [31:0]      blk_lo;
	logic [31:0]      blk_hi;
	logic             blk_ioc;
	logic [22:0]      blk_left;
	logic [22:0]      blk_off;
	logic [4:0]       idx;
	logic [2:0]       pkt_words;
	logic [15:0]      sg_idx;
	logic [63:0]      hdr_addr;
	logic [63:0]      tbl_base;
	logic [63:0]      blk_base;
	logic [63:0]      next_addr;
	logic [4:0]       fis_len;
	logic [15:0]      sg_len;
	logic [22:0]      step;
	logic             tx_take;
	logic             rx_valid;
	logic [31:0]      rx_data;
	logic             rx_pop;

	initial begin
		if (NUM_SLOTS < 1 || NUM_SLOTS > 32 || (NUM_SLOTS & (NUM_SLOTS - 1)) != 0)
			$error("pcd_port_dma: slot count must be a power of two up to 32");
	end

	// received data is buffered so the link can run ahead of memory writes
	pcd_fifo #(.WIDTH(32), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
		.i_clk       (I_REF_CLK),
		.i_srst      (I_SRST),
		.i_in_valid  (I_RX_VALID),
		.i_in_data   (I_RX_DATA),
		.o_in_ready  (O_RX_READY),
		.o_out_valid (rx_valid),
		.o_out_data  (rx_data),
		.i_out_ready (rx_pop)
	);

	// address forming; upper halves forced to zero on narrow parts
	always_comb begin
		hdr_addr = (I_WIDE_ADDRESS_CAPABLE ? I_LIST_BASE : {32'h0, I_LIST_BASE[31:0]})
			+ (64'(slot) << HDR_SLOT_SH);
		tbl_base = {(I_WIDE_ADDRESS_CAPABLE ? tbl_hi : 32'h0),
			tbl_lo[31:TBL_BASE_LSB], 7'h00};
		blk_base = {(I_WIDE_ADDRESS_CAPABLE ? blk_hi : 32'h0),
			blk_lo[31:BLK_BASE_LSB], 1'b0};
		case (state)
			ST_HDR:  next_addr = hdr_addr + 64'({idx, 2'b00});
			ST_FIS:  next_addr = tbl_base + 64'({idx, 2'b00});
			ST_PKT:  next_addr = tbl_base + 64'(TBL_OFS_PKT) + 64'({idx, 2'b00});
			ST_SG:   next_addr = tbl_base + 64'(TBL_OFS_SG)
				+ (64'(sg_idx) << SG_ENTRY_SH) + 64'({idx, 2'b00});
			ST_DATA: next_addr = blk_base + 64'(blk_off);
			ST_WB:   next_addr = hdr_addr + 64'(HDR_OFS_COUNT);
			default: next_addr = hdr_addr + 64'(HDR_OFS_FLAGS);
		endcase
	end

	// illegal short or long frame lengths are clamped into range
	assign fis_len = (hdr_flags[CFL_MSB:CFL_LSB] < CFL_MIN) ? CFL_MIN
		: (hdr_flags[CFL_MSB:CFL_LSB] > CFL_MAX) ? CFL_MAX
		: hdr_flags[CFL_MSB:CFL_LSB];
	assign sg_len  = hdr_flags[SG_LEN_MSB:SG_LEN_LSB];
	assign step    = (blk_left >= WORD_BYTES) ? WORD_BYTES : blk_left;
	assign tx_take = O_TX_VALID && I_TX_READY;
	assign rx_pop  = (state == ST_DATA) && !hdr_flags[WRITE_BIT] && !O_MEM_REQ && rx_valid;

	// command sequencer, memory requests and transmit word; one engine per port
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			state                    <= ST_IDLE;
			slot                     <= '0;
			idx                      <= '0;
			hdr_flags                <= '0;
			tbl_lo                   <= '0;
			tbl_hi                   <= '0;
			blk_lo                   <= '0;
			blk_hi                   <= '0;
			blk_ioc                  <= 1'b0;
			blk_left                 <= '0;
			blk_off                  <= '0;
			pkt_words                <= '0;
			sg_idx                   <= '0;
			O_MEM_REQ                <= 1'b0;
			O_MEM_WE                 <= 1'b0;
			O_MEM_ADDR               <= '0;
			O_MEM_WDATA              <= '0;
			O_TX_VALID               <= 1'b0;
			O_TX_DATA                <= '0;
			O_TRANSFERRED_BYTE_COUNT <= '0;
		end else begin
			if (I_MEM_ACK)
				O_MEM_REQ <= 1'b0;
			if (tx_take)
				O_TX_VALID <= 1'b0;
			// words bound for the link are fetched and passed on untouched
			if ((state == ST_FIS || state == ST_PKT || (state == ST_DATA
					&& hdr_flags[WRITE_BIT])) && O_MEM_REQ && I_MEM_ACK) begin
				O_TX_VALID <= 1'b1;
				O_TX_DATA  <= I_MEM_RDATA;
			end
			if ((state == ST_HDR || state == ST_SG || ((state == ST_FIS
					|| state == ST_PKT || state == ST_DATA) && hdr_flags[WRITE_BIT] | state != ST_DATA)
					&& !O_TX_VALID) && !O_MEM_REQ) begin
				O_MEM_REQ  <= 1'b1;
				O_MEM_WE   <= 1'b0;
				O_MEM_ADDR <= next_addr;
			end
			case (state)
				ST_IDLE: begin
					// linear scan of the issue bitmap, one slot per cycle
					if (I_COMMAND_ISSUE_BITMAP[slot] && !served[slot]) begin
						state                    <= ST_HDR;
						idx                      <= 5'(HDR_DW_FLAGS);
						sg_idx                   <= '0;
						O_TRANSFERRED_BYTE_COUNT <= '0;
					end else begin
						slot <= (slot == SW'(NUM_SLOTS - 1)) ? '0 : slot + 1'b1;
					end
				end
				ST_HDR: begin
					if (O_MEM_REQ && I_MEM_ACK) begin
						if (idx == 5'(HDR_DW_FLAGS)) begin
							hdr_flags <= I_MEM_RDATA;
							idx       <= 5'(HDR_DW_TBL_LO);
						end else if (idx == 5'(HDR_DW_TBL_LO)) begin
							tbl_lo <= I_MEM_RDATA;
							idx    <= 5'(HDR_DW_TBL_HI);
						end else begin
							tbl_hi <= I_MEM_RDATA;
							state  <= ST_BUSY;
						end
					end
				end
				ST_BUSY: begin
					// one cycle to raise busy before any frame word leaves
					state <= ST_FIS;
					idx   <= '0;
				end
				ST_FIS: begin
					if (tx_take) begin
						idx <= idx + 1'b1;
						if (idx == fis_len - 1'b1) begin
							idx   <= '0;
							state <= hdr_flags[ATAPI_BIT] ? ST_PKT_WAIT
								: (sg_len == '0) ? ST_WB : ST_SG;
						end
					end
				end
				ST_PKT_WAIT: begin
					// the device's pio setup decides how much packet to send
					if (I_PIO_SETUP_VALID) begin
						pkt_words <= I_PIO_SETUP_BYTES[4:2];
						idx       <= '0;
						// an empty packet request must still walk the entries
						state     <= (I_PIO_SETUP_BYTES[4:2] != '0) ? ST_PKT
							: (sg_len == '0) ? ST_WB : ST_SG;
					end
				end
				ST_PKT: begin
					if (tx_take) begin
						idx <= idx + 1'b1;
						if (idx == 5'(pkt_words) - 1'b1) begin
							idx   <= '0;
							state <= (sg_len == '0) ? ST_WB : ST_SG;
						end
					end
				end
				ST_SG: begin
					if (O_MEM_REQ && I_MEM_ACK) begin
						if (idx == 5'(SG_DW_BASE_LO)) begin
							blk_lo <= I_MEM_RDATA;
							idx    <= 5'(SG_DW_BASE_HI);
						end else if (idx == 5'(SG_DW_BASE_HI)) begin
							blk_hi <= I_MEM_RDATA;
							idx    <= 5'(SG_DW_INFO);
						end else begin
							blk_ioc  <= I_MEM_RDATA[IOC_BIT];
							blk_left <= {1'b0, I_MEM_RDATA[DBC_MSB:0]} + 23'h000001;
							blk_off  <= '0;
							state    <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (rx_pop) begin
						O_MEM_REQ   <= 1'b1;
						O_MEM_WE    <= 1'b1;
						O_MEM_ADDR  <= next_addr;
						O_MEM_WDATA <= rx_data;
					end
					if (hdr_flags[WRITE_BIT] ? tx_take : (O_MEM_REQ && I_MEM_ACK)) begin
						O_TRANSFERRED_BYTE_COUNT <= O_TRANSFERRED_BYTE_COUNT + 32'(step);
						blk_left                 <= blk_left - step;
						blk_off                  <= blk_off + WORD_BYTES;
						if (blk_left <= WORD_BYTES)
							state <= ST_DESC_END;
					end
				end
				ST_DESC_END: begin
					sg_idx <= sg_idx + 1'b1;
					idx    <= '0;
					state  <= (sg_idx + 1'b1 == sg_len) ? ST_WB : ST_SG;
				end
				ST_WB: begin
					// byte count is written back into header dword 1
					if (idx == '0 && !O_MEM_REQ) begin
						O_MEM_REQ   <= 1'b1;
						O_MEM_WE    <= 1'b1;
						O_MEM_ADDR  <= next_addr;
						O_MEM_WDATA <= O_TRANSFERRED_BYTE_COUNT;
						idx         <= 5'h01;
					end else if (O_MEM_REQ && I_MEM_ACK) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
					slot  <= (slot == SW'(NUM_SLOTS - 1)) ? '0 : slot + 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// a slot is served once per issue; dropping its issue bit re-arms it
	for (genvar s = 0; s < 32; s++) begin : g_served
		always_ff @(posedge I_REF_CLK) begin
			if (I_SRST || s >= NUM_SLOTS)
				served[s] <= 1'b0;
			else if (state == ST_DONE && 32'(slot) == s)
				served[s] <= 1'b1;
			else if (!I_COMMAND_ISSUE_BITMAP[s])
				served[s] <= 1'b0;
		end
	end

	// busy and completion reporting
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_TASKFILE_BUSY_FLAG <= 1'b0;
			O_CMD_DONE           <= 1'b0;
			O_CMD_SLOT           <= '0;
		end else begin
			O_CMD_DONE <= state == ST_DONE;
			O_CMD_SLOT <= 5'(slot);
			if (state == ST_BUSY)
				O_TASKFILE_BUSY_FLAG <= 1'b1;
			else if (state == ST_DONE)
				O_TASKFILE_BUSY_FLAG <= 1'b0;
		end
	end

	// descriptor done flag; a new event wins over a clear in the same cycle
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_DESCRIPTOR_DONE_FLAG <= 1'b0;
			O_IRQ                  <= 1'b0;
		end else begin
			if (state == ST_DESC_END && blk_ioc)
				O_DESCRIPTOR_DONE_FLAG <= 1'b1;
			else if (I_DESCRIPTOR_DONE_CLR)
				O_DESCRIPTOR_DONE_FLAG <= 1'b0;
			O_IRQ <= I_IRQ_ENABLE && (O_DESCRIPTOR_DONE_FLAG
				|| (state == ST_DESC_END && blk_ioc));
		end
	end

	a_busy_before_frame: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_FIS && O_TX_VALID) |-> O_TASKFILE_BUSY_FLAG)
		else $error("frame word sent without busy set");
	a_narrow_upper_zero: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(O_MEM_REQ && !I_WIDE_ADDRESS_CAPABLE) |-> O_MEM_ADDR[63:32] == 32'h0)
		else $error("upper address bits set on narrow part");
	a_table_low_bits: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_FIS && O_MEM_REQ) |-> O_MEM_ADDR[6:0] == {idx, 2'b00})
		else $error("table base low bits not ignored");
	a_packet_only_atapi: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_PKT || state == ST_PKT_WAIT) |-> hdr_flags[ATAPI_BIT])
		else $error("packet sent for non packet command");
	a_packet_length: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_PKT) |-> idx < 5'(pkt_words))
		else $error("packet words beyond pio setup request");
	a_no_entries_no_data: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_SG || state == ST_DATA) |-> sg_len != 16'h0 && sg_idx < sg_len)
		else $error("entry fetched beyond list length");
	a_entry_order: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_DESC_END && sg_idx + 1'b1 != sg_len) |=> state == ST_SG
		&& sg_idx == $past(sg_idx) + 1'b1)
		else $error("entries not walked in order");
	a_done_flag_set: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_DESC_END && blk_ioc) |=> O_DESCRIPTOR_DONE_FLAG
		##1 (O_IRQ == $past(I_IRQ_ENABLE)))
		else $error("descriptor done flag not raised");
	a_count_accumulates: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		(state == ST_DATA && hdr_flags[WRITE_BIT] && tx_take) |=>
		O_TRANSFERRED_BYTE_COUNT == $past(O_TRANSFERRED_BYTE_COUNT) + 32'($past(step)))
		else $error("byte count not accumulated");
endmodule

/* common/pcd_pkg.sv */
// constants and state type for the port command and descriptor dma block
package pcd_pkg;
	// command header layout, byte offsets within one 32-byte slot
	localparam logic [5:0]  HDR_OFS_FLAGS  = 6'h00;
	localparam logic [5:0]  HDR_OFS_COUNT  = 6'h04;
	localparam int          HDR_SLOT_SH    = 5;
	localparam logic [1:0]  HDR_DW_FLAGS   = 2'h0;
	localparam logic [1:0]  HDR_DW_TBL_LO  = 2'h2;
	localparam logic [1:0]  HDR_DW_TBL_HI  = 2'h3;
	// header dword 0 fields
	localparam int          CFL_LSB        = 0;
	localparam int          CFL_MSB        = 4;
	localparam int          ATAPI_BIT      = 5;
	localparam int          WRITE_BIT      = 6;
	localparam int          SG_LEN_LSB     = 16;
	localparam int          SG_LEN_MSB     = 31;
	localparam int          TBL_BASE_LSB   = 7;
	localparam logic [4:0]  CFL_MIN        = 5'h02;
	localparam logic [4:0]  CFL_MAX        = 5'h10;
	// command table layout
	localparam logic [7:0]  TBL_OFS_PKT    = 8'h40;
	localparam logic [7:0]  TBL_OFS_SG     = 8'h80;
	localparam int          SG_ENTRY_SH    = 4;
	localparam logic [1:0]  SG_DW_BASE_LO  = 2'h0;
	localparam logic [1:0]  SG_DW_BASE_HI  = 2'h1;
	localparam logic [1:0]  SG_DW_INFO     = 2'h3;
	// descriptor fields
	localparam int          BLK_BASE_LSB   = 1;
	localparam int          IOC_BIT        = 31;
	localparam int          DBC_MSB        = 21;
	localparam logic [22:0] WORD_BYTES     = 23'h000004;
	// data fifo depth between link receive and memory writes
	localparam int          RX_FIFO_DEPTH  = 8;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_HDR      = 4'h1,
		ST_BUSY     = 4'h2,
		ST_FIS      = 4'h3,
		ST_PKT_WAIT = 4'h4,
		ST_PKT      = 4'h5,
		ST_SG       = 4'h6,
		ST_DATA     = 4'h7,
		ST_DESC_END = 4'h8,
		ST_WB       = 4'h9,
		ST_DONE     = 4'ha
	} pcd_state_type;
endpackage

/* src/pcd_fifo.sv */
// small synchronous fifo with valid and ready on both sides
module pcd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             wr;
	logic             rd;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("pcd_fifo: depth must be a power of two of at least 2");
	end

	assign wr = i_in_valid && o_in_ready;
	assign rd = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr];

	// count next value; full and empty are kept as flops so ready is clean
	always_comb begin
		next_count = count;
		if (wr && !rd)
			next_count = count + 1'b1;
		else if (rd && !wr)
			next_count = count - 1'b1;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			count       <= '0;
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			o_in_ready  <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			count       <= next_count;
			o_in_ready  <= next_count != (PW + 1)'(DEPTH);
			o_out_valid <= next_count != '0;
			if (wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	// storage carries no reset, it is only read behind valid
	always_ff @(posedge i_clk) begin
		if (wr)
			mem[wr_ptr] <= i_in_data;
	end
endmodule

/* sim/pcd_mem_model.sv */
// memory partner model: sparse word store behind the dma memory port
module pcd_mem_model (
	// clock and pacing
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	// request side
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [63:0] i_addr,
	input  wire logic [31:0] i_wdata,
	// answer side
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [logic [63:0]];
	int          wait_left = -1;
	initial o_ack = 1'b0;
	initial o_rdata = 32'h0;
	// one ack per request; data churns when idle so stale words never match
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack) begin
			if (wait_left < 0)
				wait_left = i_slow ? $urandom_range(3, 0) : 0;
			if (wait_left == 0) begin
				o_ack <= 1'b1;
				if (i_we)
					mem[i_addr] = i_wdata;
				else if (mem.exists(i_addr))
					o_rdata <= mem[i_addr];
				wait_left = -1;
			end else
				wait_left--;
		end
	end
endmodule

/* sim/test_pcd_port_dma.sv */
// self-checking bench for the port command dma with a memory model
module test_pcd_port_dma
	import pcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] LB = 64'h0000_0003_0001_0000;
	logic        I_REF_CLK = 1'b0, I_SRST = 1'b1, slow = 1'b0;
	logic [31:0] I_COMMAND_ISSUE_BITMAP = 32'h0;
	logic        I_WIDE_ADDRESS_CAPABLE = 1'b0, I_IRQ_ENABLE = 1'b0;
	logic        I_DESCRIPTOR_DONE_CLR = 1'b0, I_PIO_SETUP_VALID = 1'b0;
	logic [4:0]  I_PIO_SETUP_BYTES = 5'h00;
	logic        I_TX_READY = 1'b0, I_RX_VALID = 1'b0, I_MEM_ACK;
	logic [31:0] I_RX_DATA = 32'h0, I_MEM_RDATA, O_MEM_WDATA, O_TX_DATA;
	logic [31:0] O_TRANSFERRED_BYTE_COUNT;
	logic [63:0] O_MEM_ADDR;
	logic        O_MEM_REQ, O_MEM_WE, O_TX_VALID, O_RX_READY, O_TASKFILE_BUSY_FLAG;
	logic        O_DESCRIPTOR_DONE_FLAG, O_IRQ, O_CMD_DONE;
	logic [4:0]  O_CMD_SLOT;
	logic [31:0] txq[$], rxq[$];
	bit          rx_popped, saw_full;
	int          num_errors = 0, checks_done = 0, atapi_runs = 0;

	pcd_port_dma DUT (.I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST),
		.I_COMMAND_ISSUE_BITMAP(I_COMMAND_ISSUE_BITMAP), .I_LIST_BASE(LB),
		.I_WIDE_ADDRESS_CAPABLE(I_WIDE_ADDRESS_CAPABLE), .I_IRQ_ENABLE(I_IRQ_ENABLE),
		.I_DESCRIPTOR_DONE_CLR(I_DESCRIPTOR_DONE_CLR), .I_PIO_SETUP_VALID(I_PIO_SETUP_VALID),
		.I_PIO_SETUP_BYTES(I_PIO_SETUP_BYTES), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
		.O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .I_MEM_ACK(I_MEM_ACK),
		.I_MEM_RDATA(I_MEM_RDATA), .O_TX_VALID(O_TX_VALID), .O_TX_DATA(O_TX_DATA),
		.I_TX_READY(I_TX_READY), .I_RX_VALID(I_RX_VALID), .I_RX_DATA(I_RX_DATA),
		.O_RX_READY(O_RX_READY), .O_TASKFILE_BUSY_FLAG(O_TASKFILE_BUSY_FLAG),
		.O_DESCRIPTOR_DONE_FLAG(O_DESCRIPTOR_DONE_FLAG), .O_IRQ(O_IRQ),
		.O_TRANSFERRED_BYTE_COUNT(O_TRANSFERRED_BYTE_COUNT), .O_CMD_DONE(O_CMD_DONE),
		.O_CMD_SLOT(O_CMD_SLOT));
	pcd_mem_model mm (.i_clk(I_REF_CLK), .i_slow(slow), .i_req(O_MEM_REQ), .i_we(O_MEM_WE),
		.i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));

	always #5 I_REF_CLK = ~I_REF_CLK;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// bytes of one entry from its zero-based count
	function automatic int entry_bytes(input int dbc);
		return dbc + 1;
	endfunction

	// words one entry moves; the last word may be partly filled
	function automatic int entry_words(input int dbc);
		return (entry_bytes(dbc) + 3) / 4;
	endfunction

	// link sink and port monitors, sampled on the design's own edge
	always @(posedge I_REF_CLK) begin
		if (O_TX_VALID && I_TX_READY)
			txq.push_back(O_TX_DATA);
		if (O_TX_VALID)
			check(O_TASKFILE_BUSY_FLAG, 1, "busy before frame");
		if (O_MEM_REQ && !I_WIDE_ADDRESS_CAPABLE)
			check(O_MEM_ADDR[63:32], 0, "upper address");
		if (I_RX_VALID && !O_RX_READY)
			saw_full = 1'b1;
		if (I_RX_VALID && O_RX_READY) begin
			void'(rxq.pop_front());
			rx_popped = 1'b1;
		end
	end

	// receive source holds a word until taken; stalls at random
	always @(negedge I_REF_CLK) begin
		I_TX_READY = $urandom_range(1, 0);
		if (!I_RX_VALID || rx_popped) begin
			I_RX_VALID = rxq.size() > 0 && $urandom_range(1, 0);
			rx_popped = 1'b0;
		end
		I_RX_DATA = I_RX_VALID ? rxq[0] : ~I_RX_DATA;
	end

	// builds one command in memory, issues it and checks every effect
	task automatic run_cmd(input int slot, input int command_frame_length, input bit atapi, input bit wr,
		input int nent);
		logic [63:0] hb, tb, bb, sg, ra[$];
		logic [31:0] tlo, thi, blo, bhi, w, exq[$], rv[$];
		int          dbc, total, n, pio;
		bit          ioc, anyioc;
		total = 0;
		anyioc = 0;
		hb = (I_WIDE_ADDRESS_CAPABLE ? LB : {32'h0, LB[31:0]}) + 64'(slot * 32);
		tlo = $urandom;
		thi = $urandom;
		tb = {I_WIDE_ADDRESS_CAPABLE ? thi : 32'h0, tlo & 32'hffff_ff80};
		mm.mem[hb] = {16'(nent), 9'h0, wr, atapi, 5'(command_frame_length)};
		mm.mem[hb + 4] = $urandom;
		mm.mem[hb + 8] = tlo;
		mm.mem[hb + 12] = thi;
		for (int i = 0; i < command_frame_length; i++) begin
			w = $urandom;
			mm.mem[tb + 64'(4 * i)] = w;
			exq.push_back(w);
		end
		// every third packet command gets an empty request, so no packet words go out
		pio = (atapi_runs % 3 == 2) ? 0 : $urandom_range(1, 0) ? 12 : 16;
		if (atapi)
			atapi_runs++;
		for (int i = 0; i < 4; i++) begin
			w = $urandom;
			mm.mem[tb + 64'h40 + 64'(4 * i)] = w;
			if (atapi && i < pio / 4)
				exq.push_back(w);
		end
		for (int e = 0; e < nent; e++) begin
			sg = tb + 64'h80 + 64'(16 * e);
			blo = $urandom & 32'hffff_fffe;
			bhi = $urandom;
			bb = {I_WIDE_ADDRESS_CAPABLE ? bhi : 32'h0, blo};
			dbc = 2 * $urandom_range(31, 0) + 1;
			ioc = $urandom_range(1, 0);
			anyioc |= ioc;
			mm.mem[sg] = blo | 32'h1;
			mm.mem[sg + 4] = bhi;
			mm.mem[sg + 12] = {ioc, 9'h0, 22'(dbc)};
			total += entry_bytes(dbc);
			for (int k = 0; k < entry_words(dbc); k++) begin
				w = $urandom;
				if (wr) begin
					mm.mem[bb + 64'(4 * k)] = w;
					exq.push_back(w);
				end else begin
					rxq.push_back(w);
					ra.push_back(bb + 64'(4 * k));
					rv.push_back(w);
				end
			end
		end
		txq.delete();
		@(negedge I_REF_CLK) I_COMMAND_ISSUE_BITMAP[slot] = 1'b1;
		if (atapi) begin
			for (n = 0; n < 2000 && txq.size() < command_frame_length; n++)
				@(negedge I_REF_CLK);
			I_PIO_SETUP_VALID = 1'b1;
			I_PIO_SETUP_BYTES = 5'(pio);
			@(negedge I_REF_CLK) I_PIO_SETUP_VALID = 1'b0;
		end
		for (n = 0; n < 4000 && O_CMD_DONE !== 1'b1; n++)
			@(negedge I_REF_CLK);
		check(O_CMD_DONE, 1, "command done");
		check(O_CMD_SLOT, slot, "slot");
		check(O_TRANSFERRED_BYTE_COUNT, total, "byte count");
		check(mm.mem[hb + 4], total, "count written back");
		check(txq.size(), exq.size(), "link words");
		for (int i = 0; i < exq.size() && i < txq.size(); i++)
			check(txq[i], exq[i], "link word");
		foreach (ra[i])
			check(mm.mem[ra[i]], rv[i], "received word");
		check(O_DESCRIPTOR_DONE_FLAG, anyioc, "done flag");
		check(O_IRQ, anyioc & I_IRQ_ENABLE, "irq");
		I_COMMAND_ISSUE_BITMAP[slot] = 1'b0;
		@(negedge I_REF_CLK) I_DESCRIPTOR_DONE_CLR = 1'b1;
		@(negedge I_REF_CLK) I_DESCRIPTOR_DONE_CLR = 1'b0;
		check(O_DESCRIPTOR_DONE_FLAG, 0, "flag cleared");
		check(O_TASKFILE_BUSY_FLAG, 0, "busy released");
	endtask

	// main sequence: reset, corner lengths, then random commands
	initial begin
		void'($urandom(32'h4273));
		repeat (6) @(negedge I_REF_CLK);
		check({O_MEM_REQ, O_TX_VALID, O_RX_READY, O_CMD_DONE}, 0, "outputs in reset");
		I_SRST = 1'b0;
		for (int n = 0; n < 14; n++) begin
			I_WIDE_ADDRESS_CAPABLE = n[0];
			I_IRQ_ENABLE = $urandom_range(1, 0);
			slow = (n % 3 == 0);
			run_cmd($urandom_range(31, 0), n == 0 ? 2 : n == 1 ? 16 : $urandom_range(16, 2),
				n % 4 == 2, n == 3 ? 1'b0 : 1'($urandom_range(1, 0)),
				n < 2 ? 0 : $urandom_range(3, 1));
		end
		check(saw_full, 1, "receive buffer refused");
		tally_and_finish();
	end

	// watchdog: commands take a few hundred cycles; the per-command limits expire first
	initial begin
		#900_000;
		num_errors++;
		tally_and_finish();
	end
endmodule
